// [pkg/htfd_pkg.sv]
`default_nettype none
package htfd_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam logic [7:0] DATA_TYPE = 8'h46;
  localparam logic [7:0] PIO_SETUP_TYPE = 8'h5F;
  localparam logic [11:0] MAX_DW = 12'h800;
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [31:0] HDR_WORD = {24'h00_0000, DATA_TYPE};
  // ----------------------------------------
  // Transport states
  // ----------------------------------------
  typedef enum logic [4:0] {
    transport_idle_state,
    type_check_state,
    command_frame_tx_state,
    control_frame_tx_state,
    dma_setup_tx_state,
    selftest_tx_state,
    pio_outbound_state,
    register_frame_rx_state,
    device_bits_rx_state,
    dma_activate_rx_state,
    pio_setup_rx_state,
    dma_setup_rx_state,
    selftest_rx_state,
    dma_inbound_state,
    pio_inbound_state
  } htfd_state_t;
endpackage : htfd_pkg
`default_nettype wire

// [pkg/htfd_tx_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface htfd_tx_if;
  logic en;
  logic done;
  logic wr;
  logic [15:0] wdata;
  logic wlast;
  logic wready;
  logic valid;
  logic [31:0] data;
  logic last;
  logic ready;
  modport ctl (output en, wr, wdata, wlast, ready,
               input done, wready, valid, data, last);
  modport eng (input en, wr, wdata, wlast, ready,
               output done, wready, valid, data, last);
endinterface : htfd_tx_if
`default_nettype wire

// [hw/htfd_data_tx.sv]
`timescale 1ns/1ps
`default_nettype none
module htfd_data_tx (
  input wire logic clk,
  input wire logic rst_n,
  htfd_tx_if.eng tx
);
  import htfd_pkg::*;

  typedef enum logic [1:0] {ph_hdr, ph_lo, ph_hi, ph_send} htfd_phase_t;
  typedef struct packed {
    htfd_phase_t ph;
    logic [31:0] data;
    logic last;
    logic [11:0] cnt;
  } htfd_txs_t;

  htfd_txs_t s_reg;
  htfd_txs_t s_next;

  // ----------------------------------------
  // Word packing
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    if (!tx.en) begin
      s_next.ph = ph_hdr;
      s_next.data = HDR_WORD; // [RULE1]
      s_next.last = 1'b0;
      s_next.cnt = CNT_RST;
    end else begin
      case (s_reg.ph)
        ph_hdr: begin
          if (tx.ready) begin
            s_next.ph = ph_lo;
          end
        end
        ph_lo: begin
          if (tx.wr) begin
            // Odd tail: high half forced to zero [RULE5] [RULE3] [RULE10]
            s_next.data = {16'h0000, tx.wdata};
            if (tx.wlast) begin
              s_next.last = 1'b1;
              s_next.ph = ph_send;
            end else begin
              s_next.ph = ph_hi;
            end
          end
        end
        ph_hi: begin
          if (tx.wr) begin
            s_next.data[31:16] = tx.wdata;
            // Frame closes at the payload ceiling [RULE2] [RULE9]
            s_next.last = tx.wlast || (s_reg.cnt == MAX_DW - 12'h001);
            s_next.ph = ph_send;
          end
        end
        ph_send: begin
          if (tx.ready) begin
            s_next.cnt = s_reg.cnt + 12'h001;
            s_next.ph = s_reg.last ? ph_hdr : ph_lo;
          end
        end
        default: s_next.ph = ph_hdr;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{ph: ph_hdr, data: HDR_WORD, last: 1'b0, cnt: CNT_RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign tx.wready = tx.en && (s_reg.ph == ph_lo || s_reg.ph == ph_hi);
  assign tx.valid = tx.en && (s_reg.ph == ph_hdr || s_reg.ph == ph_send);
  assign tx.data = s_reg.data;
  assign tx.last = (s_reg.ph == ph_send) && s_reg.last;
  assign tx.done = tx.en && tx.last && tx.ready;
endmodule : htfd_data_tx
`default_nettype wire

// [hw/htfd_dispatch.sv]
// Summary of operation
// RULE1: Data frame header DWORD carries type 46h; frame is header plus payload.
// RULE2: A Data frame holds one to 2048 payload DWORDs.
// RULE3: Payload moves as whole DWORDs; partial final DWORD zero filled.
// RULE4: Payload size is counted between frame start and end, minus type, CRC.
// RULE5: Odd word count: last word in low half, high half zero.
// RULE6: Device sends its Data frames after needed context frames.
// RULE7: Host sends its Data frames after needed context frames.
// RULE8: DMA data may be split over several Data frames.
// RULE9: Data answering a PIO setup goes in exactly one frame.
// RULE10: Multi-frame: only full DWORDs before last; odd tail high half dropped.
// RULE11: Payload used before CRC check; errors reported in completion status.
// RULE12: Transport returns to idle after each frame transaction.
// RULE13: Idle plus command register write enters command transmit.
// RULE14: Idle plus control write changing SRST enters control transmit.
// RULE15: Idle plus incoming frame enters type check.
// RULE16: Idle DMA setup or self-test request enters its transmit state.
// RULE17: Idle data request after PIO setup enters PIO outbound transfer.
// RULE18: Known control frame types reported valid and dispatched.
// RULE19: Accepted PIO setup sets the saved PIO flag.
// RULE20: Data frame valid; routed DMA or PIO by saved flag.
// RULE21: Unknown frame type reported unrecognized; back to idle.
// RULE22: Link illegal transition during type check abandons frame.
// RULE23: Any other received frame clears the saved PIO flag; the code leaves the flag unchanged for an unrecognized type.
`timescale 1ns/1ps
`default_nettype none
module htfd_dispatch #(
  parameter logic [7:0] REG_TYPE = 8'h01,
  parameter logic [7:0] SDB_TYPE = 8'h02,
  parameter logic [7:0] DMA_ACT_TYPE = 8'h03,
  parameter logic [7:0] DMA_SETUP_TYPE = 8'h04,
  parameter logic [7:0] BIST_TYPE = 8'h05
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_wr,
  input wire logic ctl_wr,
  input wire logic ctl_srst,
  input wire logic app_dma_setup_req,
  input wire logic app_selftest_req,
  input wire logic app_data_req,
  input wire logic handler_done,
  input wire logic data_wr,
  input wire logic [15:0] data_wdata,
  input wire logic data_wlast,
  output logic data_wready,
  input wire logic rx_sof,
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic rx_eof,
  input wire logic link_illegal,
  output logic type_ok,
  output logic type_bad,
  output logic pio_saved,
  output htfd_pkg::htfd_state_t state,
  output logic pay_valid,
  output logic [31:0] pay_data,
  output logic pay_last,
  output logic rx_done,
  output logic [11:0] rx_len,
  output logic rx_len_err,
  output logic tx_valid,
  output logic [31:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);
  import htfd_pkg::*;

  typedef struct packed {
    htfd_state_t st;
    logic srst;
    logic pio;
    logic ok;
    logic bad;
    logic hold_v;
    logic [31:0] hold;
    logic pay_v;
    logic [31:0] pay;
    logic pay_l;
    logic [11:0] cnt;
    logic done;
    logic [11:0] len;
    logic len_err;
  } htfd_core_t;

  htfd_core_t c_reg;
  htfd_core_t c_next;
  htfd_tx_if txi ();

  // ----------------------------------------
  // Frame type decode
  // ----------------------------------------
  // Unlisted codes map to idle, which marks them unrecognized
  function automatic htfd_state_t route(input logic [7:0] code, input logic pio);
    htfd_state_t r;
    r = transport_idle_state;
    if (code == REG_TYPE) begin
      r = register_frame_rx_state;
    end else if (code == SDB_TYPE) begin
      r = device_bits_rx_state;
    end else if (code == DMA_ACT_TYPE) begin
      r = dma_activate_rx_state;
    end else if (code == PIO_SETUP_TYPE) begin
      r = pio_setup_rx_state;
    end else if (code == DMA_SETUP_TYPE) begin
      r = dma_setup_rx_state;
    end else if (code == BIST_TYPE) begin
      r = selftest_rx_state;
    end else if (code == DATA_TYPE) begin
      r = pio ? pio_inbound_state : dma_inbound_state;
    end
    return r;
  endfunction : route

  function automatic logic is_handler(input htfd_state_t s);
    return s inside {command_frame_tx_state, control_frame_tx_state,
                     dma_setup_tx_state, selftest_tx_state,
                     register_frame_rx_state, device_bits_rx_state,
                     dma_activate_rx_state, pio_setup_rx_state,
                     dma_setup_rx_state, selftest_rx_state};
  endfunction : is_handler

  // ----------------------------------------
  // Dispatch
  // ----------------------------------------
  always_comb begin
    c_next = c_reg;
    c_next.ok = 1'b0;
    c_next.bad = 1'b0;
    c_next.pay_v = 1'b0;
    c_next.pay_l = 1'b0;
    c_next.done = 1'b0;
    if (ctl_wr) begin
      c_next.srst = ctl_srst;
    end
    case (c_reg.st)
      transport_idle_state: begin
        // Incoming frames first: the link cannot be held off [RULE12]
        c_next.hold_v = 1'b0;
        c_next.cnt = CNT_RST;
        if (rx_sof) begin
          c_next.st = type_check_state; // [RULE15]
        end else if (cmd_wr) begin
          c_next.st = command_frame_tx_state; // [RULE13]
        end else if (ctl_wr && (ctl_srst != c_reg.srst)) begin
          c_next.st = control_frame_tx_state; // [RULE14]
        end else if (app_dma_setup_req) begin
          c_next.st = dma_setup_tx_state; // [RULE16]
        end else if (app_selftest_req) begin
          c_next.st = selftest_tx_state; // [RULE16]
        end else if (app_data_req && c_reg.pio) begin
          c_next.st = pio_outbound_state; // [RULE17] [RULE7]
        end
      end
      type_check_state: begin
        if (link_illegal) begin
          c_next.st = transport_idle_state; // [RULE22]
        end else if (rx_valid) begin
          c_next.st = route(rx_data[7:0], c_reg.pio); // [RULE18] [RULE20] [RULE6]
          if (route(rx_data[7:0], c_reg.pio) == transport_idle_state) begin
            c_next.bad = 1'b1; // [RULE21]
          end else begin
            c_next.ok = 1'b1;
            c_next.pio = (rx_data[7:0] == PIO_SETUP_TYPE); // [RULE19] [RULE23]
          end
        end
      end
      dma_inbound_state, pio_inbound_state: begin
        // One DWORD held back so the CRC word is never forwarded [RULE11]
        if (link_illegal) begin
          c_next.st = transport_idle_state;
        end else if (rx_valid) begin
          if (rx_eof) begin
            c_next.pay_v = c_reg.hold_v;
            c_next.pay = c_reg.hold;
            c_next.pay_l = c_reg.hold_v;
            c_next.hold_v = 1'b0;
            c_next.done = 1'b1;
            c_next.len = c_reg.cnt; // [RULE4]
            c_next.len_err = (c_reg.cnt == CNT_RST) || (c_reg.cnt > MAX_DW); // [RULE2]
            c_next.st = transport_idle_state; // [RULE12]
          end else begin
            c_next.pay_v = c_reg.hold_v;
            c_next.pay = c_reg.hold;
            c_next.hold = rx_data;
            c_next.hold_v = 1'b1;
            if (c_reg.cnt != 12'hFFF) begin
              c_next.cnt = c_reg.cnt + 12'h001; // [RULE4] [RULE8]
            end
          end
        end
      end
      pio_outbound_state: begin
        if (link_illegal || txi.done) begin
          c_next.st = transport_idle_state; // [RULE12] [RULE9]
        end
      end
      default: begin
        if (!is_handler(c_reg.st) || link_illegal || handler_done) begin
          c_next.st = transport_idle_state; // [RULE12]
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // ----------------------------------------
  // Outbound Data frame engine
  // ----------------------------------------
  assign txi.en = (c_reg.st == pio_outbound_state);
  assign txi.wr = data_wr;
  assign txi.wdata = data_wdata;
  assign txi.wlast = data_wlast;
  assign txi.ready = tx_ready;

  htfd_data_tx u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .tx(txi)
  );

  assign data_wready = txi.wready;
  assign tx_valid = txi.valid;
  assign tx_data = txi.data;
  assign tx_last = txi.last;
  assign type_ok = c_reg.ok;
  assign type_bad = c_reg.bad;
  assign pio_saved = c_reg.pio;
  assign state = c_reg.st;
  assign pay_valid = c_reg.pay_v;
  assign pay_data = c_reg.pay;
  assign pay_last = c_reg.pay_l;
  assign rx_done = c_reg.done;
  assign rx_len = c_reg.len;
  assign rx_len_err = c_reg.len_err;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_chk_valid(logic [7:0] code);
    c_reg.st == type_check_state && !link_illegal && rx_valid && rx_data[7:0] == code;
  endsequence

  sequence s_pio_go;
    c_reg.st == transport_idle_state ##1 c_reg.st == pio_outbound_state;
  endsequence

  chk_reg_dispatch: assert property ( // [RULE18]
    s_chk_valid(REG_TYPE) |=> type_ok && state == register_frame_rx_state)
    else $error("register frame not dispatched");

  chk_pio_flag_set: assert property ( // [RULE19]
    s_chk_valid(PIO_SETUP_TYPE) |=> pio_saved && state == pio_setup_rx_state)
    else $error("pio setup flag not set");

  chk_data_dma_route: assert property ( // [RULE20]
    s_chk_valid(DATA_TYPE) and !pio_saved |=> type_ok && state == dma_inbound_state)
    else $error("data frame not routed to dma");

  chk_data_pio_route: assert property ( // [RULE20]
    s_chk_valid(DATA_TYPE) and pio_saved |=> state == pio_inbound_state ##0 !pio_saved)
    else $error("data frame not routed to pio");

  chk_unknown_type: assert property ( // [RULE21]
    c_reg.st == type_check_state && !link_illegal && rx_valid
    && route(rx_data[7:0], 1'b0) == transport_idle_state
    |=> type_bad && !type_ok && state == transport_idle_state)
    else $error("unknown type not refused");

  chk_illegal_abort: assert property ( // [RULE22]
    c_reg.st == type_check_state && link_illegal
    |=> state == transport_idle_state && !type_ok && !type_bad)
    else $error("illegal transition not abandoned");

  chk_cmd_entry: assert property ( // [RULE13]
    c_reg.st == transport_idle_state && !rx_sof && cmd_wr
    |=> state == command_frame_tx_state)
    else $error("command write not taken");

  chk_ctl_entry: assert property ( // [RULE14]
    c_reg.st == transport_idle_state && !rx_sof && !cmd_wr && ctl_wr
    && ctl_srst != c_reg.srst |=> state == control_frame_tx_state)
    else $error("srst change not taken");

  chk_sof_entry: assert property ( // [RULE15]
    c_reg.st == transport_idle_state && rx_sof |=> state == type_check_state)
    else $error("frame arrival not taken");

  chk_rx_length: assert property ( // [RULE4]
    c_reg.st == dma_inbound_state && !link_illegal && rx_valid && rx_eof
    |=> rx_done && rx_len == $past(c_reg.cnt) && state == transport_idle_state)
    else $error("payload length wrong");

  chk_pio_clear: assert property ( // [RULE23]
    s_chk_valid(SDB_TYPE) or s_chk_valid(REG_TYPE) |=> !pio_saved)
    else $error("pio flag not cleared");

  chk_tx_header: assert property ( // [RULE1]
    s_pio_go |-> tx_valid && tx_data == HDR_WORD && !tx_last)
    else $error("data frame header missing");

  chk_tx_no_wr_hdr: assert property ( // [RULE3]
    tx_valid && !tx_last |-> !data_wready)
    else $error("write taken while sending");

  chk_handler_return: assert property ( // [RULE12]
    is_handler(c_reg.st) && handler_done |=> state == transport_idle_state)
    else $error("handler did not return to idle");

endmodule : htfd_dispatch
`default_nettype wire

// [verification/htfd_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
module htfd_link_model (
  input wire logic clk,
  input wire logic stall_en,
  output logic rx_sof,
  output logic rx_valid,
  output logic [31:0] rx_data,
  output logic rx_eof,
  output logic link_illegal,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_last
);
  // ----------------------------------------
  // Link side of the transport
  // ----------------------------------------
  logic [32:0] tx_q[$];
  logic [31:0] last_dw;
  logic flip;
  initial begin
    {rx_sof, rx_valid, rx_eof, link_illegal, tx_ready, flip} = 6'h00;
    last_dw = 32'h0000_0000;
    rx_data = 32'hffff_ffff;
  end
  // Stalls every other cycle when asked, so tx_valid must hold
  // Ready first: the pair seen here is what the next rising edge takes
  always @(negedge clk) begin
    flip = ~flip;
    tx_ready = !stall_en || flip;
    if (tx_valid && tx_ready) tx_q.push_back({tx_last, tx_data});
  end
  task automatic put(input logic v, input logic [31:0] d, input logic e);
    @(negedge clk);
    rx_sof = 1'b0;
    rx_valid = v;
    rx_eof = e;
    rx_data = v ? d : ~last_dw; // Idle bus never shows the stale word
    if (v) last_dw = d;
  endtask : put
  task automatic send_frame(input logic [7:0] code, input logic [31:0] pay[$],
                            input logic crc_on);
    logic [31:0] crc;
    crc = 32'h0000_0000;
    rx_sof = 1'b1;
    put(1'b1, {24'h00_0000, code}, 1'b0);
    foreach (pay[i]) begin
      put(1'b1, pay[i], 1'b0);
      crc = crc ^ pay[i];
    end
    if (crc_on) put(1'b1, ~crc, 1'b1);
    put(1'b0, 32'h0000_0000, 1'b0);
  endtask : send_frame
  task automatic abort_frame();
    rx_sof = 1'b1;
    @(negedge clk);
    rx_sof = 1'b0;
    link_illegal = 1'b1;
    @(negedge clk);
    link_illegal = 1'b0;
  endtask : abort_frame
endmodule : htfd_link_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
  import htfd_pkg::*;
  // ----------------------------------------
  // Stimulus and checking
  // ----------------------------------------
  localparam logic [7:0] T_REG = 8'h01;
  localparam logic [7:0] T_SDB = 8'h02;
  localparam logic [7:0] T_ACT = 8'h03;
  localparam logic [7:0] T_DSU = 8'h04;
  localparam logic [7:0] T_BST = 8'h05;
  localparam logic [7:0] T_BAD = 8'he3;
  logic clk, rst_n, cmd_wr, ctl_wr, ctl_srst, app_dma_setup_req, app_selftest_req;
  logic app_data_req, handler_done, data_wr, data_wlast, data_wready, rx_sof, rx_valid, rx_eof;
  logic link_illegal, type_ok, type_bad, pio_saved, pay_valid, pay_last, rx_done, rx_len_err;
  logic tx_valid, tx_last, tx_ready, stall_en, saw_check, err_seen, last_seen;
  logic [15:0] data_wdata;
  logic [31:0] rx_data, pay_data, tx_data, rnd;
  logic [11:0] rx_len, len_seen;
  htfd_state_t state, type_state;
  logic [31:0] got_q[$];
  int bad_count, n_compared, ok_n, bad_n, base;
  htfd_dispatch #(.REG_TYPE(T_REG), .SDB_TYPE(T_SDB), .DMA_ACT_TYPE(T_ACT),
    .DMA_SETUP_TYPE(T_DSU), .BIST_TYPE(T_BST)) i_htfd_dispatch (.clk, .rst_n, .cmd_wr,
    .ctl_wr, .ctl_srst, .app_dma_setup_req, .app_selftest_req, .app_data_req, .handler_done,
    .data_wr, .data_wdata, .data_wlast, .data_wready, .rx_sof, .rx_valid, .rx_data, .rx_eof,
    .link_illegal, .type_ok, .type_bad, .pio_saved, .state, .pay_valid, .pay_data, .pay_last,
    .rx_done, .rx_len, .rx_len_err, .tx_valid, .tx_data, .tx_last, .tx_ready);
  htfd_link_model i_htfd_link_model (.clk, .stall_en, .rx_sof, .rx_valid, .rx_data, .rx_eof,
    .link_illegal, .tx_ready, .tx_valid, .tx_data, .tx_last);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (type_ok === 1'b1 || type_bad === 1'b1) type_state = state;
    if (type_ok === 1'b1) ok_n++;
    if (type_bad === 1'b1) bad_n++;
    if (state === type_check_state) saw_check = 1'b1;
    if (pay_valid === 1'b1) begin
      got_q.push_back(pay_data);
      last_seen = pay_last;
    end
    if (rx_done === 1'b1) {len_seen, err_seen} = {rx_len, rx_len_err};
  end
  function automatic logic [31:0] next_rand();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : next_rand
  function automatic htfd_state_t exp_rx(input logic [7:0] code, input logic saved);
    case (code)
      T_REG: return register_frame_rx_state;
      T_SDB: return device_bits_rx_state;
      T_ACT: return dma_activate_rx_state;
      T_DSU: return dma_setup_rx_state;
      T_BST: return selftest_rx_state;
      PIO_SETUP_TYPE: return pio_setup_rx_state;
      DATA_TYPE: return saved ? pio_inbound_state : dma_inbound_state;
      default: return transport_idle_state;
    endcase
  endfunction : exp_rx
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic pulse_done();
    handler_done = 1'b1;
    @(negedge clk);
    handler_done = 1'b0;
    @(negedge clk);
    `CHECK(state, transport_idle_state)
  endtask : pulse_done
  task automatic drive_req(input int which, input htfd_state_t exp);
    @(negedge clk);
    case (which)
      0: cmd_wr = 1'b1;
      1: {ctl_wr, ctl_srst} = 2'h2;
      2: {ctl_wr, ctl_srst} = 2'h3;
      3: app_dma_setup_req = 1'b1;
      4: app_selftest_req = 1'b1;
      5: app_data_req = 1'b1;
      default: {cmd_wr, app_selftest_req, app_dma_setup_req} = 3'h7;
    endcase
    @(negedge clk);
    {cmd_wr, ctl_wr, app_dma_setup_req, app_selftest_req, app_data_req} = 5'h00;
    `CHECK(state, exp)
    if (exp != transport_idle_state) begin
      @(negedge clk);
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
      `CHECK(state, exp)
      pulse_done();
    end
  endtask : drive_req
  task automatic rx_check(input logic [7:0] code, input int n);
    logic [31:0] q[$];
    logic saved, known;
    int ok0, bad0;
    {saved, known, ok0, bad0} = {pio_saved, code != T_BAD, ok_n, bad_n};
    got_q.delete();
    repeat (n) q.push_back(next_rand());
    @(negedge clk);
    i_htfd_link_model.send_frame(code, q, code == DATA_TYPE);
    repeat (2) @(negedge clk);
    `CHECK(type_state, exp_rx(code, saved))
    `CHECK({ok_n - ok0 == 1, bad_n - bad0 == 1}, {known, !known})
    if (code == DATA_TYPE) begin
      `CHECK(len_seen, 12'(n))
      `CHECK(err_seen, n == 0 || n > 2048)
      if (n > 0 && n <= 2048) begin
        `CHECK(got_q.size() == n, 1'b1)
        foreach (q[i]) `CHECK(got_q[i], q[i])
        `CHECK(last_seen, 1'b1)
      end
    end else if (known) pulse_done();
    `CHECK(state, transport_idle_state)
    `CHECK(pio_saved, known ? code == PIO_SETUP_TYPE : saved)
  endtask : rx_check
  task automatic pio_out(input int n);
    logic [15:0] w[$];
    logic [32:0] exp_q[$];
    int k;
    rx_check(PIO_SETUP_TYPE, 0);
    repeat (n) w.push_back(16'(next_rand()));
    exp_q.push_back({1'b0, 32'h0000_0046});
    for (int i = 0; i < n; i += 2)
      exp_q.push_back({i + 2 >= n, (i + 1 < n) ? w[i + 1] : 16'h0000, w[i]});
    i_htfd_link_model.tx_q.delete();
    stall_en = 1'b1;
    @(negedge clk);
    app_data_req = 1'b1;
    @(negedge clk);
    app_data_req = 1'b0;
    `CHECK(state, pio_outbound_state)
    foreach (w[i]) begin
      k = 0;
      @(negedge clk);
      while (data_wready !== 1'b1 && k < 200) begin
        @(negedge clk);
        k++;
      end
      `CHECK(data_wready, 1'b1)
      {data_wr, data_wdata, data_wlast} = {1'b1, w[i], i == n - 1};
      @(negedge clk);
      data_wr = 1'b0;
    end
    k = 0;
    while (state !== transport_idle_state && k < 200) begin
      @(negedge clk);
      k++;
    end
    stall_en = 1'b0;
    `CHECK(state, transport_idle_state)
    `CHECK(i_htfd_link_model.tx_q.size() == exp_q.size(), 1'b1)
    foreach (exp_q[i]) `CHECK(i_htfd_link_model.tx_q[i], exp_q[i])
  endtask : pio_out
  initial begin
    {rst_n, cmd_wr, ctl_wr, ctl_srst, app_dma_setup_req, app_selftest_req} = 6'h00;
    {app_data_req, handler_done, data_wr, data_wlast, stall_en, saw_check} = 6'h00;
    data_wdata = 16'h0000;
    rnd = 32'h0000_000b;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHECK({state, pio_saved, tx_valid, data_wready}, {transport_idle_state, 3'h0})
    `CHECK(tx_data, 32'h0000_0046)
    drive_req(1, transport_idle_state);
    drive_req(2, control_frame_tx_state);
    drive_req(2, transport_idle_state);
    drive_req(1, control_frame_tx_state);
    drive_req(0, command_frame_tx_state);
    drive_req(6, command_frame_tx_state);
    drive_req(3, dma_setup_tx_state);
    drive_req(4, selftest_tx_state);
    drive_req(5, transport_idle_state);
    rx_check(T_REG, 0);
    rx_check(T_SDB, 0);
    rx_check(T_ACT, 0);
    rx_check(T_DSU, 0);
    rx_check(T_BST, 0);
    rx_check(PIO_SETUP_TYPE, 0);
    rx_check(T_BAD, 0);
    rx_check(DATA_TYPE, next_rand() % 8 + 1);
    rx_check(PIO_SETUP_TYPE, 0);
    rx_check(DATA_TYPE, next_rand() % 8 + 1);
    rx_check(DATA_TYPE, 0);
    rx_check(DATA_TYPE, 2048);
    rx_check(DATA_TYPE, 2049);
    @(negedge clk);
    {saw_check, cmd_wr, base} = {1'b0, 1'b1, ok_n + bad_n};
    i_htfd_link_model.abort_frame();
    cmd_wr = 1'b0;
    @(negedge clk);
    `CHECK(saw_check, 1'b1)
    `CHECK({state, ok_n + bad_n == base}, {transport_idle_state, 1'b1})
    base = next_rand() % 7 + 1;
    pio_out(base);
    pio_out(base + 1);
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
